// *** src/uart_mode_control.sv ***
// What this block does
// - clear, set and invert aliases sit at base plus 0x4, 0x8, 0xC
// - enable bit one: port owns pins chosen by pin usage and transmit enable
// - enable bit zero: all pins back to gpio control, port clocks gated off
// - idle stop one halts port during idle; zero keeps it running
// - infrared bit enables transmit encoder and receive decoder together
// - request pin mode one means simplex, zero means flow control
// - pin usage field picks owned pins; others stay with gpio registers
// - wake bit lets a start bit on receive pin wake from sleep
// - loop select bit places the port in loopback mode
// - bits 31-16, 14 and 10 read zero and ignore writes
//
// Purpose: mode register and pin ownership for an asynchronous serial port
// Assumes: pclk domain; transmit datapath supplies serial data and enables
// Notes:   all outputs are registered, so pin muxing lags one cycle
`timescale 1ns/1ps
module uart_mode_control
    import uart_mode_pkg::*;
(
    // clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // device power state
    input  wire logic              device_idle,
    input  wire logic              device_sleep,
    // transmit / receive datapath side
    input  wire logic              transmit_enable,
    input  wire logic              tx_serial_data,
    input  wire logic              rts_request,
    input  wire logic              rate_clock,
    output logic                   rx_serial_data,
    output logic                   cts_state,
    output logic                   port_run,
    output logic                   infrared_codec_enable,
    output logic                   request_pin_mode,
    output logic                   wake_request,
    output logic [7:0]             frame_config,
    // gpio side, used while the port does not own a pin
    input  wire logic [3:0]        gpio_output_latch,
    input  wire logic [3:0]        gpio_direction,
    output logic [3:0]             gpio_port_data,
    // serial pins
    input  wire logic              serial_receive_pin,
    input  wire logic              clear_to_send_pin,
    output logic                   serial_transmit_pin,
    output logic                   serial_transmit_pin_oe,
    output logic                   request_to_send_pin,
    output logic                   request_to_send_pin_oe,
    output logic                   rate_clock_output_pin,
    output logic                   rate_clock_output_pin_oe
);
    logic [31:0] serial_port_mode;
    logic [31:0] next_mode;
    logic [1:0]  pin_in_sync;
    logic        rx_pin;
    logic        cts_pin;
    logic        port_on;
    logic [1:0]  pin_usage_select;
    logic        own_rts;
    logic        own_cts;
    logic        own_bclk;
    logic        internal_loop_select;
    logic        rx_prev;
    logic        apb_write;
    logic [3:0]  pad_out;
    logic [3:0]  pad_in;
    logic [31:0] lane_mask;

    pin_sync #(.WIDTH(2)) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in ({clear_to_send_pin, serial_receive_pin}),
        .sync_out (pin_in_sync)
    );
    assign rx_pin  = pin_in_sync[0];
    assign cts_pin = pin_in_sync[1];

    assign port_on              = serial_port_mode[BIT_ENABLE];
    assign pin_usage_select     = serial_port_mode[BIT_PIN_USE_HI:BIT_PIN_USE_LO];
    assign internal_loop_select = serial_port_mode[BIT_LOOP];
    assign own_rts  = port_on && (pin_usage_select == USE_TX_RX_RTS ||
                                  pin_usage_select == USE_TX_RX_FLOW);
    assign own_cts  = port_on && (pin_usage_select == USE_TX_RX_FLOW);
    assign own_bclk = port_on && (pin_usage_select == USE_TX_RX_BCLK);

    assign apb_write = psel && penable && pwrite && clk_en;
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // alias writes act on the stored word; only strobed lanes change
    always_comb begin
        next_mode = serial_port_mode;
        case (paddr)
            OFF_MODE: next_mode = (serial_port_mode & ~lane_mask) | (pwdata & lane_mask);
            OFF_CLR:  next_mode = serial_port_mode & ~(pwdata & lane_mask);
            OFF_SET:  next_mode = serial_port_mode | (pwdata & lane_mask);
            OFF_INV:  next_mode = serial_port_mode ^ (pwdata & lane_mask);
            default:  next_mode = serial_port_mode;
        endcase
        next_mode = next_mode & MODE_IMPL_MASK;
    end

    // register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_port_mode <= MODE_RESET;
        end else if (apb_write) begin
            serial_port_mode <= next_mode;
        end
    end

    // apb answer: zero wait states; pslverr stays low, writes to offsets other than 0x0, 0x4, 0x8, 0xC are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                // aliases read back the base word
                prdata <= serial_port_mode & MODE_IMPL_MASK;
            end
        end
    end

    // mode outputs to the serial engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_run              <= 1'b0;
            infrared_codec_enable <= 1'b0;
            request_pin_mode      <= 1'b0;
            frame_config          <= 8'h00;
        end else if (clk_en) begin
            // disabled or idle-stopped port freezes, keeping power low
            port_run <= port_on &&
                        !(serial_port_mode[BIT_IDLE_STOP] && device_idle);
            infrared_codec_enable <= port_on && serial_port_mode[BIT_INFRARED];
            request_pin_mode      <= serial_port_mode[BIT_REQ_MODE];
            frame_config          <= serial_port_mode[7:0];
        end
    end

    // receive path, loopback and handshake input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_serial_data <= 1'b1;
            cts_state      <= 1'b0;
        end else if (clk_en) begin
            if (!port_on) begin
                rx_serial_data <= 1'b1;
            end else if (internal_loop_select) begin
                rx_serial_data <= tx_serial_data;
            end else begin
                rx_serial_data <= rx_pin;
            end
            cts_state <= own_cts ? cts_pin : 1'b0;
        end
    end

    // wake on falling edge of receive pin during sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev      <= 1'b1;
            wake_request <= 1'b0;
        end else if (clk_en) begin
            rx_prev      <= rx_pin;
            wake_request <= port_on && serial_port_mode[BIT_WAKE] &&
                            device_sleep && rx_prev && !rx_pin;
        end
    end

    // pin ownership: pad order is tx, rx, rts/bclk shared, cts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_transmit_pin      <= 1'b1;
            serial_transmit_pin_oe   <= 1'b0;
            request_to_send_pin      <= 1'b1;
            request_to_send_pin_oe   <= 1'b0;
            rate_clock_output_pin    <= 1'b0;
            rate_clock_output_pin_oe <= 1'b0;
        end else if (clk_en) begin
            // loopback keeps the line idle so the far end sees nothing
            if (port_on && transmit_enable) begin
                serial_transmit_pin    <= internal_loop_select ? 1'b1 : tx_serial_data;
                serial_transmit_pin_oe <= 1'b1;
            end else begin
                serial_transmit_pin    <= gpio_output_latch[0];
                serial_transmit_pin_oe <= !gpio_direction[0];
            end
            if (own_rts) begin
                request_to_send_pin    <= rts_request;
                request_to_send_pin_oe <= 1'b1;
            end else if (!own_bclk) begin
                request_to_send_pin    <= gpio_output_latch[2];
                request_to_send_pin_oe <= !gpio_direction[2];
            end else begin
                request_to_send_pin    <= 1'b1;
                request_to_send_pin_oe <= 1'b0;
            end
            if (own_bclk) begin
                rate_clock_output_pin    <= rate_clock;
                rate_clock_output_pin_oe <= 1'b1;
            end else begin
                rate_clock_output_pin    <= gpio_output_latch[2];
                rate_clock_output_pin_oe <= 1'b0;
            end
        end
    end

    // gpio readback of pads; tx reads back its driven level
    assign pad_out = {1'b0, request_to_send_pin, 1'b0, serial_transmit_pin};
    assign pad_in  = {cts_pin, pad_out[2], rx_pin, pad_out[0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_port_data <= 4'h0;
        end else if (clk_en) begin
            gpio_port_data <= pad_in;
        end
    end
endmodule

// *** src/uart_mode_pkg.sv ***
// Purpose: constants for the serial port mode-control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package uart_mode_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFF_MODE        = 4'h0;
    localparam logic [3:0]  OFF_CLR         = 4'h4;
    localparam logic [3:0]  OFF_SET         = 4'h8;
    localparam logic [3:0]  OFF_INV         = 4'hC;
    localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
    localparam logic [31:0] MODE_IMPL_MASK  = 32'h0000_BBFF;
    localparam int          BIT_ENABLE      = 15;
    localparam int          BIT_IDLE_STOP   = 13;
    localparam int          BIT_INFRARED    = 12;
    localparam int          BIT_REQ_MODE    = 11;
    localparam int          BIT_PIN_USE_HI  = 9;
    localparam int          BIT_PIN_USE_LO  = 8;
    localparam int          BIT_WAKE        = 7;
    localparam int          BIT_LOOP        = 6;
    localparam int          BIT_AUTO_RATE   = 5;
    localparam int          BIT_RX_INVERT   = 4;
    localparam int          BIT_HIGH_SPEED  = 3;
    localparam int          BIT_PARITY_HI   = 2;
    localparam int          BIT_PARITY_LO   = 1;
    localparam int          BIT_STOP_SEL    = 0;
    localparam logic [1:0]  USE_TX_RX       = 2'b00;
    localparam logic [1:0]  USE_TX_RX_RTS   = 2'b01;
    localparam logic [1:0]  USE_TX_RX_FLOW  = 2'b10;
    localparam logic [1:0]  USE_TX_RX_BCLK  = 2'b11;
endpackage

// *** src/pin_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: one clock, clock enable freezes state
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** tb/uart_mode_control_assertions.sv ***
// Purpose: port checks for mode control
// Assumes: clk_en held high
// Notes:   outputs lag their cause one edge
`timescale 1ns/1ps
module uart_mode_checks
    import uart_mode_pkg::*;
(
    // clock and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    // datapath and pins
    input wire logic        device_idle,
    input wire logic        tx_serial_data,
    input wire logic        rate_clock,
    input wire logic        serial_receive_pin,
    input wire logic        rx_serial_data,
    input wire logic        cts_state,
    input wire logic        port_run,
    input wire logic        infrared_codec_enable,
    input wire logic        wake_request,
    input wire logic        serial_transmit_pin,
    input wire logic        serial_transmit_pin_oe,
    input wire logic        request_to_send_pin_oe,
    input wire logic        rate_clock_output_pin,
    input wire logic        rate_clock_output_pin_oe,
    input wire logic [7:0]  frame_config
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_reserved_read_zero: assert property (pready |-> (prdata & ~MODE_IMPL_MASK) == '0)
        else $error("reserved bits read nonzero");
    a_disabled_pins_free: assert property (!port_run && !$past(device_idle)
        |-> rx_serial_data && !rate_clock_output_pin_oe && !cts_state)
        else $error("pins held while disabled");
    a_codec_needs_run: assert property (infrared_codec_enable && !$past(device_idle)
        |-> port_run)
        else $error("codec on while port off");
    a_clock_pin_follows: assert property (rate_clock_output_pin_oe
        |-> rate_clock_output_pin == $past(rate_clock) && !request_to_send_pin_oe)
        else $error("clock pin wrong");
    a_wake_after_start: assert property (wake_request
        |-> !$past(serial_receive_pin, 3) ##1 !wake_request)
        else $error("wake without start bit");
    a_loop_internal: assert property (frame_config[6] && port_run
        |-> rx_serial_data == $past(tx_serial_data))
        else $error("loop data wrong");
    a_loop_tx_idle: assert property (frame_config[6] && port_run && serial_transmit_pin_oe
        |-> serial_transmit_pin)
        else $error("tx pin active in loop");
    c_wake: cover property (wake_request);
    c_clock_pin: cover property (rate_clock_output_pin_oe);
    c_loop: cover property (frame_config[6] && port_run);
endmodule
bind uart_mode_control uart_mode_checks chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .prdata(prdata), .device_idle(device_idle), .tx_serial_data(tx_serial_data),
    .rate_clock(rate_clock), .serial_receive_pin(serial_receive_pin),
    .rx_serial_data(rx_serial_data), .cts_state(cts_state), .port_run(port_run),
    .infrared_codec_enable(infrared_codec_enable), .wake_request(wake_request),
    .serial_transmit_pin(serial_transmit_pin), .serial_transmit_pin_oe(serial_transmit_pin_oe),
    .request_to_send_pin_oe(request_to_send_pin_oe), .frame_config(frame_config),
    .rate_clock_output_pin(rate_clock_output_pin),
    .rate_clock_output_pin_oe(rate_clock_output_pin_oe)
);

// *** tb/serial_peer_model.sv ***
// Purpose: remote transceiver driving the port's input pins
// Assumes: line idles at mark level
// Notes:   sends bare start bits only
`timescale 1ns/1ps
module serial_peer_model (
    // clock
    input wire logic pclk,
    // lines toward the port
    output logic     rx_line,
    output logic     cts_line
);
    initial begin
        rx_line = 1'b1;
        cts_line = 1'b1;
    end
    // held long enough for the two-flop sync
    task automatic start_bit(input int n);
        @(posedge pclk);
        rx_line <= 1'b0;
        repeat (n) @(posedge pclk);
        rx_line <= 1'b1;
    endtask
endmodule

// *** tb/uart_mode_control_bench.sv ***
// Purpose: register and pin tests for mode control
// Assumes: gpio pads inputs, transmit enabled
// Notes:   pin checks wait four edges
`timescale 1ns/1ps
module uart_mode_control_bench
    import uart_mode_pkg::*;
();
    logic              pclk, presetn, psel, penable, pwrite, pready, device_idle, device_sleep;
    logic              tx_serial_data, rate_clock, rx_serial_data, cts_state, port_run;
    logic              infrared_codec_enable, request_pin_mode, wake_request, rx_line, cts_line;
    logic              serial_transmit_pin, serial_transmit_pin_oe, request_to_send_pin_oe;
    logic              rate_clock_output_pin_oe;
    logic              rts_request, request_to_send_pin, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, m, q, d, lm;
    logic [3:0]        pstrb, gpio_output_latch, gpio_port_data;
    logic [7:0]        frame_config;
    int                fail_count, n_tests, seen, n;
    logic [3:0]        offs [5] = '{OFF_MODE, OFF_CLR, OFF_SET, OFF_INV, OFF_MODE};
    logic [3:0]        strbs [5] = '{4'hF, 4'hF, 4'hF, 4'h5, 4'h2};
    logic [31:0]       dats [5] = '{32'hFFFF_FFFF, 32'h0000_F0F0, 32'h0000_1001,
                                    32'hFFFF_0F0F, 32'h1234_5678};
    uart_mode_control uut (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .device_idle, .device_sleep, .transmit_enable(1'b1),
        .tx_serial_data, .rts_request, .rate_clock, .rx_serial_data, .cts_state,
        .port_run, .infrared_codec_enable, .request_pin_mode, .wake_request, .frame_config,
        .gpio_output_latch, .gpio_direction(4'hF), .gpio_port_data,
        .serial_receive_pin(rx_line), .clear_to_send_pin(cts_line), .serial_transmit_pin,
        .serial_transmit_pin_oe, .request_to_send_pin, .request_to_send_pin_oe,
        .rate_clock_output_pin(), .rate_clock_output_pin_oe);
    serial_peer_model peer (.pclk, .rx_line, .cts_line);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] v,
                       input logic [3:0] st);
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    task automatic put(input logic [31:0] v);
        apb(1'b1, OFF_MODE, v, 4'hF);
        repeat (4) @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) rate_clock <= ~rate_clock;
    initial begin
        {presetn, psel, penable, pwrite, device_idle, device_sleep, rate_clock} = '0;
        {paddr, pwdata, pstrb, gpio_output_latch, rts_request} = '0;
        fail_count = 0;
        n_tests = 0;
        tx_serial_data = 1'b1;
        repeat (20) @(posedge pclk);
        check("tx pin in reset", serial_transmit_pin, 32'h1);
        presetn <= 1'b1;
        apb(1'b0, OFF_MODE, 32'h0, 4'hF);
        check("mode after reset", q, MODE_RESET);
        m = MODE_RESET;
        for (int i = 0; i < 5; i++) begin
            lm = {{8{strbs[i][3]}}, {8{strbs[i][2]}}, {8{strbs[i][1]}}, {8{strbs[i][0]}}};
            d = dats[i] & lm;
            case (offs[i])
                OFF_CLR: m = m & ~d;
                OFF_SET: m = m | d;
                OFF_INV: m = m ^ d;
                default: m = (m & ~lm) | d;
            endcase
            m = m & MODE_IMPL_MASK;
            apb(1'b1, offs[i], dats[i], strbs[i]);
            apb(1'b0, offs[i], 32'h0, 4'hF);
            check("mode word", q, m);
            check("slave error", pslverr, 32'h0);
        end
        $display("alias and reserved bit test done");
        for (int u = 0; u < 4; u++) begin
            // owned rts pin follows the engine, free pad follows the latch
            rts_request <= u[1];
            gpio_output_latch <= 4'h4;
            put(32'h0000_800F | (u << 8));
            check("rts oe", request_to_send_pin_oe, u == 1 || u == 2);
            check("rts pin", request_to_send_pin, u != 1);
            check("pad readback", gpio_port_data, (u == 1) ? 32'hB : 32'hF);
            check("clock oe", rate_clock_output_pin_oe, u == 3);
            check("cts state", cts_state, u == 2);
            check("tx oe", serial_transmit_pin_oe, 32'h1);
            check("frame bits", frame_config, 32'h0F);
        end
        apb(1'b1, OFF_CLR, 32'h0000_8000, 4'hF);
        @(posedge pclk);
        repeat (4) @(posedge pclk);
        check("run off", port_run, 32'h0);
        check("tx oe off", serial_transmit_pin_oe, 32'h0);
        check("tx pin gpio", serial_transmit_pin, 32'h0);
        check("clock oe off", rate_clock_output_pin_oe, 32'h0);
        $display("pin ownership test done");
        for (int i = 0; i < 4; i++) begin
            device_idle <= i[0];
            put(32'h0000_8000 | ((i / 2) << 13));
            check("run vs idle", port_run, i != 3);
        end
        device_idle <= 1'b0;
        put(32'h0000_1800);
        check("codec off", infrared_codec_enable, 32'h0);
        check("simplex", request_pin_mode, 32'h1);
        put(32'h0000_9000);
        check("codec on", infrared_codec_enable, 32'h1);
        check("flow control", request_pin_mode, 32'h0);
        $display("mode bit test done");
        put(32'h0000_8040);
        for (int k = 0; k < 4; k++) begin
            tx_serial_data <= k[0];
            repeat (2) @(posedge pclk);
            check("loop data", rx_serial_data, k % 2);
            check("tx idle", serial_transmit_pin, 32'h1);
        end
        device_sleep <= 1'b1;
        for (int w = 1; w >= 0; w--) begin
            put(32'h0000_8000 | (w << 7));
            seen = 0;
            fork
                peer.start_bit(8);
            join_none
            repeat (14) begin
                @(posedge pclk);
                if (wake_request === 1'b1) seen++;
            end
            check("wake pulses", seen, w);
        end
        $display("loopback and wake test done");
        tally_and_finish();
    end
endmodule
